// ===== pvit_pkg.sv
`default_nettype none
package pvit_pkg;
  // ----------------------------------------
  // colour coding
  // ----------------------------------------
  localparam int LEVEL_W = 8;
  localparam logic [7:0] LEVEL_DARK = 8'h00;
  localparam logic [7:0] LEVEL_FULL = 8'hff;
  localparam int PIX_W = 3 * LEVEL_W;
  localparam int PAIR_W = 2 * PIX_W;
  localparam int RED_LSB = 16;
  localparam int GREEN_LSB = 8;
  localparam int BLUE_LSB = 0;
  localparam int SPARE_W = 3;
  localparam logic [2:0] SPARE_LEVEL = 3'h0;
  // ----------------------------------------
  // line and frame timing, in link clock periods and lines
  // ----------------------------------------
  localparam int H_ACTIVE = 1920;
  localparam int H_BLANK_MIN = 180;
  localparam int H_BLANK_NOM = 280;
  localparam int H_BLANK_MAX = 380;
  localparam int V_ACTIVE = 1080;
  localparam int V_BLANK_MIN = 35;
  localparam int V_BLANK_NOM = 45;
  localparam int V_BLANK_MAX = 55;
  localparam int CNT_W = 12;
  // a low stretch longer than any line blank marks frame blanking
  localparam logic [11:0] FRAME_GAP = 12'(H_BLANK_MAX + 1);
  // ----------------------------------------
  // link clock and frame rates
  // ----------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int LINK_MHZ_MIN = 60;
  localparam int LINK_MHZ_NOM = 74;
  localparam int LINK_MHZ_MAX = 80;
  localparam int LINK_DIV = (CLK_MHZ + LINK_MHZ_MAX - 1) / LINK_MHZ_MAX;
  localparam int RATE50_MIN = 47;
  localparam int RATE50_MAX = 53;
  localparam int RATE60_MIN = 57;
  localparam int RATE60_MAX = 63;
endpackage
`default_nettype wire

// ===== pvit_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pvit_link_if;
  logic linkClk;
  logic dataEn;
  logic [47:0] pixPair;
  logic hSync;
  logic vSync;
  logic [2:0] spareInput;
  logic frameRateSelect;
  modport source (
    output linkClk, dataEn, pixPair, hSync, vSync, spareInput, frameRateSelect
  );
  modport panel (
    input linkClk, dataEn, pixPair, hSync, vSync, spareInput, frameRateSelect
  );
endinterface
`default_nettype wire

// ===== pvit_skid_buf.sv
`timescale 1ns/1ps
`default_nettype none
module pvit_skid_buf #(
  parameter int W = 48
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  logic [W-1:0] mem [2];
  logic wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;

  // two-entry ring, next-state
  always_comb begin
    push = inValid && (cnt_q != 2'h2);
    pop = (cnt_q != 2'h0) && outReady;
    wrPtr_d = push ? !wrPtr_q : wrPtr_q;
    rdPtr_d = pop ? !rdPtr_q : rdPtr_q;
    cnt_d = 2'(cnt_q + {1'b0, push} - {1'b0, pop});
  end

  // register state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else if (ce) begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      cnt_q <= cnt_d;
    end
  end

  // storage has no reset
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  assign inReady = (cnt_q != 2'h2);
  assign outValid = (cnt_q != 2'h0);
  assign outData = mem[rdPtr_q];
endmodule
`default_nettype wire

// ===== pvit_source.sv
`timescale 1ns/1ps
`default_nettype none
module pvit_source (
  // system clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // user side
  input wire logic userRate60,
  input wire logic [11:0] hBlank,
  input wire logic [5:0] vBlank,
  input wire logic pairValid,
  output logic pairReady,
  input wire logic [47:0] pairData,
  output logic frameStart,
  // link
  pvit_link_if.source link
);
  logic [1:0] divCnt_q, divCnt_d;
  logic linkClk_q, linkClk_d;
  logic [11:0] hCnt_q, hCnt_d;
  logic [10:0] vCnt_q, vCnt_d;
  logic [11:0] hBlankLat_q, hBlankLat_d;
  logic [5:0] vBlankLat_q, vBlankLat_d;
  logic dataEn_q, dataEn_d;
  logic [47:0] pix_q, pix_d;
  logic rate_q, rate_d;
  logic frameStart_q, frameStart_d;
  logic bufValid, bufReady;
  logic [47:0] bufData;
  logic fallEdge, active;

  // -------------------------------------
  // input buffer
  // -------------------------------------
  pvit_skid_buf #(.W(pvit_pkg::PAIR_W)) u_buf (
    .clk(clk),
    .rst(sys_rst),
    .ce(clkEn),
    .inValid(pairValid),
    .inReady(pairReady),
    .inData(pairData),
    .outValid(bufValid),
    .outReady(bufReady),
    .outData(bufData)
  );

  // -------------------------------------
  // timing generator, one link period per LINK_DIV clk periods
  // -------------------------------------
  always_comb begin
    divCnt_d = divCnt_q;
    linkClk_d = linkClk_q;
    hCnt_d = hCnt_q;
    vCnt_d = vCnt_q;
    hBlankLat_d = hBlankLat_q;
    vBlankLat_d = vBlankLat_q;
    dataEn_d = dataEn_q;
    pix_d = pix_q;
    rate_d = rate_q;
    frameStart_d = 1'b0;
    fallEdge = 1'b0;
    active = (hCnt_q < 12'(pvit_pkg::H_ACTIVE)) && (vCnt_q < 11'(pvit_pkg::V_ACTIVE));
    // divided link clock, toggled every half period
    if (divCnt_q == 2'(pvit_pkg::LINK_DIV / 2 - 1)) begin
      divCnt_d = 2'h0;
      linkClk_d = !linkClk_q;
      fallEdge = linkClk_q;
    end else begin
      divCnt_d = 2'(divCnt_q + 2'h1);
    end
    // stall while the buffer is empty inside active video
    if (fallEdge && !(active && !bufValid)) begin
      // odd pixel upper half, even lower half
      dataEn_d = active;
      pix_d = active ? bufData : 48'h0;
      if (hCnt_q == 12'(pvit_pkg::H_ACTIVE - 1) + hBlankLat_q) begin
        hCnt_d = 12'h000;
        if (vCnt_q == 11'(pvit_pkg::V_ACTIVE - 1) + 11'(vBlankLat_q)) begin
          vCnt_d = 11'h000;
          frameStart_d = 1'b1;
          hBlankLat_d = hBlank;
          vBlankLat_d = vBlank;
        end else begin
          vCnt_d = 11'(vCnt_q + 11'h001);
        end
      end else begin
        hCnt_d = 12'(hCnt_q + 12'h001);
      end
    end
    // rate select taken only at frame origin
    if (fallEdge && hCnt_q == 12'h000 && vCnt_q == 11'h000) begin
      rate_d = userRate60;
    end
  end

  assign bufReady = fallEdge && active;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      divCnt_q <= 2'h0;
      linkClk_q <= 1'b0;
      hCnt_q <= 12'h000;
      vCnt_q <= 11'h000;
      hBlankLat_q <= 12'(pvit_pkg::H_BLANK_NOM);
      vBlankLat_q <= 6'(pvit_pkg::V_BLANK_NOM);
      dataEn_q <= 1'b0;
      pix_q <= 48'h0;
      rate_q <= 1'b0;
      frameStart_q <= 1'b0;
    end else if (clkEn) begin
      divCnt_q <= divCnt_d;
      linkClk_q <= linkClk_d;
      hCnt_q <= hCnt_d;
      vCnt_q <= vCnt_d;
      hBlankLat_q <= hBlankLat_d;
      vBlankLat_q <= vBlankLat_d;
      dataEn_q <= dataEn_d;
      pix_q <= pix_d;
      rate_q <= rate_d;
      frameStart_q <= frameStart_d;
    end
  end

  // -------------------------------------
  // link drive
  // -------------------------------------
  assign link.linkClk = linkClk_q;
  assign link.dataEn = dataEn_q;
  assign link.pixPair = pix_q;
  assign link.hSync = 1'b0;
  assign link.vSync = 1'b0;
  assign link.spareInput = pvit_pkg::SPARE_LEVEL;
  assign link.frameRateSelect = rate_q;
  assign frameStart = frameStart_q;
endmodule
`default_nettype wire

// ===== pvit_panel.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - each colour is unsigned eight-bit level
// - zero is dark, 255 full intensity
// - colour bits are positive logic
// - host link clock 60 to 80 MHz
// - 1080 active lines, 35-55 blank lines
// - 1920 active periods, 180-380 blank
// - rate select picks 50 or 60 Hz
// - timing taken from data enable only
// - host holds sync inputs low
// - inputs low or floating when unpowered
// - inputs always driven while powered
// - backlight on after video, off before
// - two pixels per clock, odd first
// - bit seven most significant
// - spare inputs driven fixed level
module pvit_panel (
  // system clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // link
  pvit_link_if.panel link,
  // user side: decoded pixel stream
  output logic pixValid,
  input wire logic pixReady,
  output logic [7:0] redLevel,
  output logic [7:0] greenLevel,
  output logic [7:0] blueLevel,
  output logic pixFirst,
  output logic lineFirst,
  output logic rate60,
  output logic overflow
);
  // -------------------------------------
  // link domain: frame tracking from data enable
  // -------------------------------------
  logic lrst1_q, lrst2_q;
  logic [11:0] gap_q, gap_d;
  logic prevEn_q, prevEn_d;
  logic newFrame_q, newFrame_d;
  logic wrTog_q, wrTog_d;
  logic [49:0] bank_q [2];
  logic [49:0] bank_d [2];

  // link reset, released synchronously to linkClk
  always_ff @(posedge link.linkClk or posedge sys_rst) begin
    if (sys_rst) begin
      lrst1_q <= 1'b1;
      lrst2_q <= 1'b1;
    end else begin
      lrst1_q <= 1'b0;
      lrst2_q <= lrst1_q;
    end
  end

  // sync inputs deliberately unused; only data enable is read
  always_comb begin
    gap_d = gap_q;
    prevEn_d = link.dataEn;
    newFrame_d = newFrame_q;
    wrTog_d = wrTog_q;
    bank_d = bank_q;
    if (link.dataEn) begin
      // enabled cycle is one pixel pair
      wrTog_d = !wrTog_q;
      // ping-pong banks: a written word stays put for two link periods
      bank_d[wrTog_q] = {newFrame_q, !prevEn_q, link.pixPair};
      newFrame_d = 1'b0;
      gap_d = 12'h000;
    end else begin
      if (gap_q != pvit_pkg::FRAME_GAP) begin
        gap_d = 12'(gap_q + 12'h001);
      end else begin
        // long low stretch: next enabled line starts a frame
        newFrame_d = 1'b1;
      end
    end
  end

  always_ff @(posedge link.linkClk or posedge lrst2_q) begin
    if (lrst2_q) begin
      gap_q <= 12'h000;
      prevEn_q <= 1'b0;
      newFrame_q <= 1'b1;
      wrTog_q <= 1'b0;
      bank_q <= '{default: 50'h0};
    end else begin
      gap_q <= gap_d;
      prevEn_q <= prevEn_d;
      newFrame_q <= newFrame_d;
      wrTog_q <= wrTog_d;
      bank_q <= bank_d;
    end
  end

  // -------------------------------------
  // system domain: crossing and pixel split
  // -------------------------------------
  logic tog1_q, tog2_q, tog3_q;
  logic rs1_q, rs2_q;
  logic [49:0] cap_q, cap_d;
  logic capValid_q, capValid_d;
  logic half_q, half_d;
  logic ovf_q, ovf_d;
  logic bufInValid, bufInReady, bufOutValid, bufOutReady;
  logic [49:0] bufOut;
  logic [7:0] red_q, red_d, green_q, green_d, blue_q, blue_d;
  logic pixValid_q, pixValid_d, pixFirst_q, pixFirst_d, lineFirst_q, lineFirst_d;
  logic [23:0] pick;

  // edge of the toggle marks a held, stable word
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tog1_q <= 1'b0;
      tog2_q <= 1'b0;
      tog3_q <= 1'b0;
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else if (clkEn) begin
      tog1_q <= wrTog_q;
      tog2_q <= tog1_q;
      tog3_q <= tog2_q;
      rs1_q <= link.frameRateSelect;
      rs2_q <= rs1_q;
    end
  end

  // capture word on toggle; flag loss if buffer still full
  always_comb begin
    cap_d = cap_q;
    capValid_d = capValid_q && !bufInReady;
    ovf_d = ovf_q;
    if (tog2_q != tog3_q) begin
      // the bank just written is the one named by the old toggle
      cap_d = bank_q[tog3_q];
      capValid_d = 1'b1;
      ovf_d = ovf_q || (capValid_q && !bufInReady);
    end
  end
  assign bufInValid = capValid_q;

  pvit_skid_buf #(.W(50)) u_buf (
    .clk(clk),
    .rst(sys_rst),
    .ce(clkEn),
    .inValid(bufInValid),
    .inReady(bufInReady),
    .inData(cap_q),
    .outValid(bufOutValid),
    .outReady(bufOutReady),
    .outData(bufOut)
  );

  // odd pixel first from upper half, then even from lower
  always_comb begin
    pick = half_q ? bufOut[23:0] : bufOut[47:24];
    half_d = half_q;
    pixValid_d = pixValid_q && !pixReady;
    red_d = red_q;
    green_d = green_q;
    blue_d = blue_q;
    pixFirst_d = pixFirst_q;
    lineFirst_d = lineFirst_q;
    bufOutReady = 1'b0;
    if (bufOutValid && (!pixValid_q || pixReady)) begin
      pixValid_d = 1'b1;
      // levels passed unaltered, msb at bit 7
      red_d = pick[pvit_pkg::RED_LSB +: pvit_pkg::LEVEL_W];
      green_d = pick[pvit_pkg::GREEN_LSB +: pvit_pkg::LEVEL_W];
      blue_d = pick[pvit_pkg::BLUE_LSB +: pvit_pkg::LEVEL_W];
      pixFirst_d = bufOut[49] && !half_q;
      lineFirst_d = bufOut[48] && !half_q;
      half_d = !half_q;
      bufOutReady = half_q;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cap_q <= 50'h0;
      capValid_q <= 1'b0;
      ovf_q <= 1'b0;
      half_q <= 1'b0;
      pixValid_q <= 1'b0;
      red_q <= pvit_pkg::LEVEL_DARK;
      green_q <= pvit_pkg::LEVEL_DARK;
      blue_q <= pvit_pkg::LEVEL_DARK;
      pixFirst_q <= 1'b0;
      lineFirst_q <= 1'b0;
    end else if (clkEn) begin
      cap_q <= cap_d;
      capValid_q <= capValid_d;
      ovf_q <= ovf_d;
      half_q <= half_d;
      pixValid_q <= pixValid_d;
      red_q <= red_d;
      green_q <= green_d;
      blue_q <= blue_d;
      pixFirst_q <= pixFirst_d;
      lineFirst_q <= lineFirst_d;
    end
  end

  assign pixValid = pixValid_q;
  assign redLevel = red_q;
  assign greenLevel = green_q;
  assign blueLevel = blue_q;
  assign pixFirst = pixFirst_q;
  assign lineFirst = lineFirst_q;
  // selected rate range reported to user
  assign rate60 = rs2_q;
  assign overflow = ovf_q;
endmodule
`default_nettype wire

// ===== pvit_link_props.sv
`timescale 1ns/1ps
`default_nettype none
module pvit_link_props (
  // clocks and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic linkClk,
  // link wires
  input wire logic dataEn,
  input wire logic [47:0] pixPair,
  input wire logic hSync,
  input wire logic vSync,
  input wire logic [2:0] spareInput
);
  // ----------------------------------------
  // run length counters on the link
  // ----------------------------------------
  logic [11:0] hiCnt_q, hiCnt_d;
  logic [19:0] loCnt_q, loCnt_d;
  logic armed_q, armed_d;

  // count enabled and idle periods; arm after the first enabled run of any length ends
  always_comb begin
    hiCnt_d = dataEn ? hiCnt_q + 12'h001 : 12'h000;
    loCnt_d = dataEn ? 20'h00000 : loCnt_q + 20'h00001;
    armed_d = armed_q | (!dataEn & (hiCnt_q != 12'h000));
  end

  // register the counters
  always_ff @(posedge linkClk or posedge sys_rst) begin
    if (sys_rst) begin
      hiCnt_q <= 12'h000;
      loCnt_q <= 20'h00000;
      armed_q <= 1'b0;
    end else begin
      hiCnt_q <= hiCnt_d;
      loCnt_q <= loCnt_d;
      armed_q <= armed_d;
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_hsync_low;
    @(posedge clk) disable iff (sys_rst) !hSync;
  endproperty
  a_hsync_low: assert property (p_hsync_low) else $error("hsync not low");

  property p_vsync_low;
    @(posedge clk) disable iff (sys_rst) !vSync;
  endproperty
  a_vsync_low: assert property (p_vsync_low) else $error("vsync not low");

  property p_spare_fixed;
    @(posedge clk) disable iff (sys_rst) spareInput == pvit_pkg::SPARE_LEVEL;
  endproperty
  a_spare_fixed: assert property (p_spare_fixed) else $error("spare moved");

  property p_link_divide;
    @(posedge clk) disable iff (sys_rst) $rose(linkClk) |=> !linkClk ##1 linkClk;
  endproperty
  a_link_divide: assert property (p_link_divide) else $error("link clock ratio");

  property p_en_on_fall;
    @(posedge clk) disable iff (sys_rst) $changed(dataEn) |-> !linkClk;
  endproperty
  a_en_on_fall: assert property (p_en_on_fall) else $error("enable moved high");

  property p_pair_on_fall;
    @(posedge clk) disable iff (sys_rst) $changed(pixPair) |-> !linkClk;
  endproperty
  a_pair_on_fall: assert property (p_pair_on_fall) else $error("pair moved high");

  property p_line_active;
    @(posedge linkClk) disable iff (sys_rst)
      (armed_q && $fell(dataEn)) |-> hiCnt_q == pvit_pkg::H_ACTIVE;
  endproperty
  a_line_active: assert property (p_line_active) else $error("active run length");

  property p_run_bound;
    @(posedge linkClk) disable iff (sys_rst) hiCnt_q <= pvit_pkg::H_ACTIVE;
  endproperty
  a_run_bound: assert property (p_run_bound) else $error("active run too long");

  property p_line_blank;
    @(posedge linkClk) disable iff (sys_rst) (armed_q && $rose(dataEn)) |->
      (loCnt_q >= pvit_pkg::H_BLANK_MIN && loCnt_q <= pvit_pkg::H_BLANK_MAX) ||
      loCnt_q >= pvit_pkg::V_BLANK_MIN * (pvit_pkg::H_ACTIVE + pvit_pkg::H_BLANK_MIN);
  endproperty
  a_line_blank: assert property (p_line_blank) else $error("blank length");
endmodule
`default_nettype wire

// ===== tb_panel_video_input_timing.sv
`timescale 1ns/1ps
`default_nettype none
module tb_panel_video_input_timing;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  localparam int NPAIR = 5760;
  logic clk, sys_rst, userRate60, pairValid, pairReady, rdyS;
  logic pixValid, pixReady, pixFirst, lineFirst, rate60, overflow;
  logic [47:0] pairData;
  logic [7:0] redLevel, greenLevel, blueLevel;
  logic [31:0] seed = 32'hd838bd89;
  logic [25:0] expQ[$];
  logic [25:0] e;
  int nFail = 0;
  int nChecks = 0;
  int sent = 0;
  int idle = 0;

  pvit_link_if link ();
  pvit_source u_pvit_source (.clk(clk), .sys_rst(sys_rst), .clkEn(1'b1),
    .userRate60(userRate60), .hBlank(12'h0b4), .vBlank(6'h23), .pairValid(pairValid),
    .pairReady(pairReady), .pairData(pairData), .frameStart(), .link(link));
  pvit_panel u_pvit_panel (.clk(clk), .sys_rst(sys_rst), .clkEn(1'b1), .link(link),
    .pixValid(pixValid), .pixReady(pixReady), .redLevel(redLevel),
    .greenLevel(greenLevel), .blueLevel(blueLevel), .pixFirst(pixFirst),
    .lineFirst(lineFirst), .rate60(rate60), .overflow(overflow));
  pvit_link_props u_pvit_link_props (.clk(clk), .sys_rst(sys_rst),
    .linkClk(link.linkClk), .dataEn(link.dataEn), .pixPair(link.pixPair),
    .hSync(link.hSync), .vSync(link.vSync), .spareInput(link.spareInput));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // basic colours and a walking bit first, then random levels
  function automatic logic [47:0] pairFor(int i);
    logic [31:0] r;
    logic [23:0] odd, even;
    odd = {{8{i[2]}}, {8{i[1]}}, {8{i[0]}}};
    even = 24'h000001 << (i % 24);
    if (i >= 24) begin
      r = rnd();
      odd = r[23:0];
      r = rnd();
      even = r[23:0];
    end
    return {odd, even};
  endfunction

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    nChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (nFail == 0 && nChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------
  // clock, watchdog, source driver, pixel monitor
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // the whole run takes about 120 us, so this leaves ample margin
  initial begin
    #300000;
    nFail++;
    summarize();
  end

  // ready as seen just before the taking edge
  always @(negedge clk) rdyS = pairReady;

  // note both pixels of each accepted pair, odd pixel first
  always @(posedge clk) begin
    if (!sys_rst && pairValid && rdyS === 1'b1) begin
      expQ.push_back({1'(sent == 0), 1'(sent % 1920 == 0), pairData[47:24]});
      expQ.push_back({2'b00, pairData[23:0]});
      sent++;
      #1;
      pairData = pairFor(sent);
      if (sent == NPAIR)
        pairValid = 1'b0;
    end
  end

  // compare every pixel handed over with the oldest note
  always @(negedge clk) begin
    if (pixValid === 1'b1 && pixReady === 1'b1) begin
      e = (expQ.size() > 0) ? expQ.pop_front() : 26'bx;
      check({redLevel, greenLevel, blueLevel}, e[23:0]);
      check({23'h0, lineFirst}, {23'h0, e[24]});
      check({23'h0, pixFirst}, {23'h0, e[25]});
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1;
    userRate60 = 1'b0;
    pixReady = 1'b1;
    pairValid = 1'b0;
    pairData = pairFor(0);
    repeat (3) @(posedge clk);
    #1 sys_rst = 1'b0;
    // rate select reaches the panel in both settings, link held at frame origin
    for (int v = 1; v >= 0; v--) begin
      @(posedge clk);
      #1 userRate60 = v[0];
      for (int k = 0; k < 40 && rate60 !== v[0]; k++)
        @(negedge clk);
      check({23'h0, rate60}, {23'h0, v[0]});
    end
    // three full lines; random receiver stalls once the link has idled a while
    @(posedge clk);
    #1 pairValid = 1'b1;
    while (pairValid || expQ.size() > 0) begin
      @(posedge clk);
      #1 idle = link.dataEn ? 0 : idle + 1;
      pixReady = (idle < 16) || ((rnd() % 8) != 0);
    end
    check({23'h0, overflow}, 24'h0);
    // receiver refuses everything: lost pairs must show
    pixReady = 1'b0;
    pairValid = 1'b1;
    repeat (1600) @(posedge clk);
    #1 check({23'h0, overflow}, 24'h1);
    summarize();
  end
endmodule
`default_nettype wire
